//--- src/rvip_pkg.sv
// constants, state encodings and the state record of the reset vector and
// interrupt priority unit
// assumes an 8-bit register window at the system register page
package rvip_pkg;

  // register offsets
  localparam logic [7:0]  RVIP_OFS_OPTION  = 8'h39;
  localparam logic [7:0]  RVIP_OFS_PRIO    = 8'h3C;
  localparam logic [7:0]  RVIP_OFS_SETUP   = 8'h3F;

  // field positions
  localparam int          RVIP_B_BOOT      = 7;
  localparam int          RVIP_B_SPC       = 6;
  localparam int          RVIP_B_MODEA     = 5;
  localparam int          RVIP_B_IRV       = 4;
  localparam int          RVIP_B_WDD       = 2;
  localparam int          RVIP_B_ROM       = 1;
  localparam int          RVIP_B_IRQE      = 5;
  localparam int          RVIP_B_OSCDLY    = 4;
  localparam int          RVIP_B_CLKMON    = 3;

  // values after reset
  localparam logic [3:0]  RVIP_PSEL_RST    = 4'h5;
  localparam logic        RVIP_OSCDLY_RST  = 1'b1;
  localparam logic        RVIP_CLKMON_RST  = 1'b0;
  localparam logic        RVIP_IRQE_RST    = 1'b0;
  localparam logic [1:0]  RVIP_RATE_RST    = 2'h0;
  localparam logic        RVIP_IRV_RST     = 1'b0;
  localparam logic [7:0]  RVIP_MAP_INIT    = 8'h00;
  localparam logic [15:0] RVIP_TIMER_INIT  = 16'h0000;
  localparam logic [15:0] RVIP_CMP_INIT    = 16'hFFFF;
  localparam logic [3:0]  RVIP_SER_BITS    = 4'h8;

  // vectors
  localparam logic [15:0] RVIP_VEC_RST_NRM = 16'hFFFE;
  localparam logic [15:0] RVIP_VEC_RST_SPC = 16'hBFFE;
  localparam logic [15:0] RVIP_VEC_ILLEGAL = 16'hFFF8;
  localparam logic [15:0] RVIP_VEC_SWTRAP  = 16'hFFF6;
  localparam logic [15:0] RVIP_VEC_NMIPIN  = 16'hFFF4;
  localparam logic [15:0] RVIP_VEC_MSK_TOP = 16'hFFF2;

  // cycle counts and maskable source count
  localparam logic [1:0]  RVIP_FETCH_CYC   = 2'h3;
  localparam logic [6:0]  RVIP_ONCE_WIN    = 7'h40;
  localparam int          RVIP_NUM_MASK    = 15;

  typedef enum logic [1:0] {
    RVIP_ST_RESET = 2'b00,
    RVIP_ST_FETCH = 2'b01,
    RVIP_ST_RUN   = 2'b10
  } rvip_state_e;

  typedef enum logic [1:0] {
    RVIP_CAUSE_POR  = 2'b00,
    RVIP_CAUSE_CLK  = 2'b01,
    RVIP_CAUSE_WDOG = 2'b10
  } rvip_cause_e;

  typedef struct packed {
    rvip_state_e state;
    rvip_cause_e cause;
    logic [1:0]  fetch_cnt;
    logic [6:0]  win_cnt;
    logic        spc_mode;
    logic        mode_a;
    logic        boot_rd;
    logic        irv;
    logic [3:0]  psel;
    logic        wdd;
    logic        wdd_wr;
    logic        rom_en;
    logic        irqe;
    logic        osc_dly;
    logic        clk_mon;
    logic [1:0]  rate;
    logic [7:0]  rdata;
    logic [15:0] vec;
    logic        vec_valid;
    logic        fetch;
    logic        run;
    logic        flags_set;
    logic        periph_init;
    logic        expansion;
    logic        wdog_en;
  } rvip_regs_s;

endpackage

//--- src/rvip_top.sv
// reset vector selection, reset state and interrupt priority arbiter
// assumes requests arrive already gated by their local enables and that the
// core reports its mask bits and instruction boundaries on ref_clk
`timescale 1ns/1ps
`default_nettype none
module rvip_top
  import rvip_pkg::*;
#(
  parameter logic ROM_ON_RESET = 1'b1
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // mode pins
  input  wire logic        mode_pin_a,
  input  wire logic        mode_pin_b,
  // reset and non-maskable events
  input  wire logic        clock_fail_event,
  input  wire logic        watchdog_timeout_event,
  input  wire logic        nonmaskable_pin_request,
  input  wire logic        illegal_opcode_req,
  input  wire logic        software_trap_req,
  // maskable requests, default priority order, bit 0 highest
  input  wire logic [14:0] maskable_req,
  // core side
  input  wire logic        cpu_i_mask,
  input  wire logic        cpu_x_mask,
  input  wire logic        instr_boundary,
  output logic      [15:0] vector_addr,
  output logic             vector_fetch,
  output logic             vector_valid,
  output logic             core_run,
  output logic             flags_mask_set,
  output logic      [1:0]  reset_cause,
  // system configuration
  output logic             periph_init,
  output logic             expansion_bus,
  output logic             watchdog_enable,
  output logic      [1:0]  watchdog_rate_select,
  output logic             osc_start_delay,
  output logic             clock_fail_detect_enable,
  output logic             irq_edge_select,
  output logic             boot_rom_read,
  output logic             special_mode_flag,
  output logic             mode_a_latched,
  output logic             internal_read_visibility,
  output logic             onchip_rom_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  localparam rvip_regs_s RVIP_RST = '{
    state: RVIP_ST_RESET, cause: RVIP_CAUSE_POR, fetch_cnt: 2'h0,
    win_cnt: 7'h00, spc_mode: 1'b0, mode_a: 1'b0, boot_rd: 1'b0, irv: RVIP_IRV_RST,
    psel: RVIP_PSEL_RST, wdd: 1'b0, wdd_wr: 1'b0, rom_en: 1'b0,
    irqe: RVIP_IRQE_RST, osc_dly: RVIP_OSCDLY_RST, clk_mon: RVIP_CLKMON_RST,
    rate: RVIP_RATE_RST, rdata: 8'h00, vec: 16'h0000, vec_valid: 1'b0,
    fetch: 1'b0, run: 1'b0, flags_set: 1'b1, periph_init: 1'b1,
    expansion: 1'b0, wdog_en: 1'b0};

  // promoted source index for a priority select code
  function automatic logic [3:0] psel_src(input logic [3:0] p);
    logic [3:0] r;
    r = 4'h0;
    unique case (p)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: r = p + 4'hA;
      4'h5, 4'h6:                   r = 4'h0;
      4'h7:                         r = 4'h1;
      default:                      r = p - 4'h6;
    endcase
    return r;
  endfunction

  // lowest set index wins
  function automatic logic [3:0] first_src(input logic [14:0] q);
    logic [3:0] r;
    r = 4'h0;
    for (int k = RVIP_NUM_MASK - 1; k >= 0; k--) begin
      if (q[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] mask_vec(input logic [3:0] idx);
    return RVIP_VEC_MSK_TOP - {11'h000, idx, 1'b0};
  endfunction

  function automatic logic [15:0] reset_vec(input rvip_cause_e c, input logic spc);
    return (spc ? RVIP_VEC_RST_SPC : RVIP_VEC_RST_NRM) - {13'h0000, c, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  rvip_regs_s st;
  rvip_regs_s nx;
  logic [3:0] top_src;
  logic [3:0] win_src;
  logic       soft_clk;
  logic       soft_wdog;

  assign top_src   = psel_src(st.psel);
  assign win_src   = maskable_req[top_src] ? top_src : first_src(maskable_req);
  assign soft_clk  = clock_fail_event && st.clk_mon && (st.state == RVIP_ST_RUN);
  assign soft_wdog = watchdog_timeout_event && st.wdog_en;

  always_comb begin
    nx = st;
    nx.rdata = 8'h00;
    nx.vec_valid = 1'b0;
    if (st.win_cnt != RVIP_ONCE_WIN) begin
      nx.win_cnt = st.win_cnt + 7'h01;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        RVIP_OFS_PRIO:   nx.rdata = {st.boot_rd & st.spc_mode, st.spc_mode, st.mode_a, st.irv, st.psel};
        RVIP_OFS_SETUP:  nx.rdata = {5'h00, st.wdd, st.rom_en, 1'b0};
        RVIP_OFS_OPTION: nx.rdata = {2'h0, st.irqe, st.osc_dly, st.clk_mon, 1'b0, st.rate};
        default:         nx.rdata = 8'h00;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        RVIP_OFS_PRIO: begin
          if (cpu_i_mask) begin
            nx.psel = reg_wdata[3:0];
            nx.irv  = reg_wdata[RVIP_B_IRV];
            if (st.spc_mode) begin
              nx.boot_rd = reg_wdata[RVIP_B_BOOT];
            end
          end
        end
        RVIP_OFS_SETUP: begin
          if (st.spc_mode || !st.wdd_wr) begin
            nx.wdd    = reg_wdata[RVIP_B_WDD];
            nx.wdd_wr = 1'b1;
          end
        end
        RVIP_OFS_OPTION: begin
          nx.clk_mon = reg_wdata[RVIP_B_CLKMON];
          if (st.spc_mode || st.win_cnt != RVIP_ONCE_WIN) begin
            nx.irqe    = reg_wdata[RVIP_B_IRQE];
            nx.osc_dly = reg_wdata[RVIP_B_OSCDLY];
            nx.rate = reg_wdata[1:0];
          end
        end
        default: ;
      endcase
    end
    unique case (st.state)
      RVIP_ST_RESET: begin
        nx.spc_mode  = ~mode_pin_b;
        nx.mode_a    = mode_pin_a;
        nx.boot_rd   = ~mode_pin_b & ~mode_pin_a;
        nx.wdd       = ~mode_pin_b;
        nx.rom_en    = ROM_ON_RESET;
        nx.expansion = mode_pin_a;
        nx.vec       = reset_vec(st.cause, ~mode_pin_b);
        nx.fetch     = 1'b1;
        nx.fetch_cnt = 2'h0;
        nx.state     = RVIP_ST_FETCH;
      end
      RVIP_ST_FETCH: begin
        nx.fetch_cnt = st.fetch_cnt + 2'h1;
        if (st.fetch_cnt == RVIP_FETCH_CYC - 2'h1) begin
          nx.fetch       = 1'b0;
          nx.run         = 1'b1;
          nx.flags_set   = 1'b0;
          nx.periph_init = 1'b0;
          nx.state       = RVIP_ST_RUN;
        end
      end
      RVIP_ST_RUN: begin
        if (instr_boundary) begin
          if (nonmaskable_pin_request && !cpu_x_mask) begin
            nx.vec = RVIP_VEC_NMIPIN;
            nx.vec_valid = 1'b1;
          end else if (illegal_opcode_req) begin
            nx.vec = RVIP_VEC_ILLEGAL;
            nx.vec_valid = 1'b1;
          end else if (software_trap_req) begin
            nx.vec = RVIP_VEC_SWTRAP;
            nx.vec_valid = 1'b1;
          end else if (!cpu_i_mask && |maskable_req) begin
            nx.vec = mask_vec(win_src);
            nx.vec_valid = 1'b1;
          end
        end
      end
      default: nx.state = RVIP_ST_RESET;
    endcase
    // internal resets restart everything; clock monitor outranks watchdog
    if (soft_clk) begin
      nx = RVIP_RST;
      nx.cause = RVIP_CAUSE_CLK;
    end else if (soft_wdog) begin
      nx = RVIP_RST;
      nx.cause = RVIP_CAUSE_WDOG;
    end
    nx.wdog_en = ~nx.wdd && (nx.state != RVIP_ST_RESET);
  end

  // every reset value, including flags, masks and peripheral init, comes from RVIP_RST
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= RVIP_RST;
    end else begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata                = st.rdata;
  assign vector_addr              = st.vec;
  assign vector_fetch             = st.fetch;
  assign vector_valid             = st.vec_valid;
  assign core_run                 = st.run;
  assign flags_mask_set           = st.flags_set;
  assign reset_cause              = st.cause;
  assign periph_init              = st.periph_init;
  assign expansion_bus            = st.expansion;
  assign watchdog_enable          = st.wdog_en;
  assign watchdog_rate_select     = st.rate;
  assign osc_start_delay          = st.osc_dly;
  assign clock_fail_detect_enable = st.clk_mon;
  assign irq_edge_select          = st.irqe;
  // boot_rd is only ever set while spc_mode is set, so the flop drives the pin directly
  assign boot_rom_read            = st.boot_rd;
  assign special_mode_flag        = st.spc_mode;
  assign mode_a_latched           = st.mode_a;
  assign internal_read_visibility = st.irv;
  assign onchip_rom_enable        = st.rom_en;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence fetch_go;
    $rose(st.fetch);
  endsequence

  sequence fetch_body;
    st.fetch[*3] ##1 (st.run && !st.fetch);
  endsequence

  wdd_init_a: assert property (fetch_go |-> st.wdd == st.spc_mode)
    else $error("watchdog disable wrong after reset");
  wdd_once_a: assert property ((reg_wr && reg_addr == RVIP_OFS_SETUP && st.wdd_wr && !st.spc_mode
                                && st.state == RVIP_ST_RUN && !soft_clk && !soft_wdog) |=> $stable(st.wdd))
    else $error("second watchdog disable write accepted");
  wdog_gate_a: assert property ((watchdog_timeout_event && st.wdd && st.state == RVIP_ST_RUN
                                 && !soft_clk) |=> st.state == RVIP_ST_RUN)
    else $error("disabled watchdog caused reset");
  setup_read_a: assert property ((reg_rd && reg_addr == RVIP_OFS_SETUP) |=>
                                 (reg_rdata[7:4] == 4'h0 && !reg_rdata[0]))
    else $error("setup unimplemented bits not zero");
  rst_vec_a: assert property (fetch_go |-> (vector_addr[15:14] == (st.spc_mode ? 2'b10 : 2'b11))
                              && (vector_addr[3:0] == 4'hE - {1'b0, st.cause, 1'b0}))
    else $error("reset vector wrong");
  fetch_len_a: assert property (fetch_go |-> fetch_body)
    else $error("restart fetch not three cycles");
  mask_set_a: assert property (st.fetch |-> flags_mask_set && periph_init)
    else $error("masks not set during restart");
  psel_init_a: assert property (fetch_go |-> st.psel == RVIP_PSEL_RST && !st.irqe)
    else $error("priority select not at reset value");
  psel_guard_a: assert property ((reg_wr && reg_addr == RVIP_OFS_PRIO && !cpu_i_mask
                                  && !soft_clk && !soft_wdog) |=> $stable(st.psel))
    else $error("priority written while unmasked");
  boot_read_a: assert property ((reg_rd && reg_addr == RVIP_OFS_PRIO && !st.spc_mode) |=> !reg_rdata[7])
    else $error("boot rom bit visible outside special mode");
  promote_a: assert property ((st.state == RVIP_ST_RUN && instr_boundary && !nonmaskable_pin_request
                               && !illegal_opcode_req && !software_trap_req && !cpu_i_mask
                               && maskable_req[top_src] && !soft_clk && !soft_wdog)
                              |=> vector_valid && vector_addr == mask_vec($past(top_src)))
    else $error("promoted source not served first");

endmodule
`default_nettype wire

//--- bench/rvip_core_model.sv
// core stand-in: follows the restart fetch, holds the x and i masks,
// issues instruction boundaries and records each vector handed over
// assumes sw_i, sw_x_clr and step change just after rising edges
`timescale 1ns/1ps
`default_nettype none
module rvip_core_model
  import rvip_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // unit side
  input  wire logic [15:0] vector_addr,
  input  wire logic        vector_fetch,
  input  wire logic        vector_valid,
  input  wire logic        core_run,
  input  wire logic        flags_mask_set,
  output logic             cpu_i_mask,
  output logic             cpu_x_mask,
  output logic             instr_boundary,
  // software side
  input  wire logic        sw_i,
  input  wire logic        sw_x_clr,
  input  wire logic        step,
  output logic      [15:0] last_vec,
  output logic      [15:0] boot_vec,
  output int               n_vec,
  output int               fetch_len
);
  logic fetch_d;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_i_mask     <= 1'b1;
      cpu_x_mask     <= 1'b1;
      instr_boundary <= 1'b0;
      fetch_d        <= 1'b0;
      last_vec       <= 16'h0000;
      boot_vec       <= 16'h0000;
      n_vec          <= 0;
      fetch_len      <= 0;
    end else begin
      instr_boundary <= step & core_run;
      fetch_d        <= vector_fetch;
      if (flags_mask_set) begin
        cpu_i_mask <= 1'b1;
        cpu_x_mask <= 1'b1;
      end else begin
        cpu_i_mask <= sw_i;
        // x can only be cleared by software; only flags_mask_set during a restart sets it again
        if (sw_x_clr)
          cpu_x_mask <= 1'b0;
      end
      if (vector_fetch) begin
        fetch_len <= fetch_d ? fetch_len + 1 : 1;
        if (!fetch_d)
          boot_vec <= vector_addr;
      end
      if (vector_valid) begin
        last_vec <= vector_addr;
        n_vec    <= n_vec + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/reset_vector_and_irq_priority_test.sv
// testbench: restart vectors, reset state, setup writes, interrupt order
// assumes the core model as partner and one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module reset_vector_and_irq_priority_test
  import rvip_pkg::*;
;
  logic        ref_clk, rstn, reg_wr, reg_rd, mode_pin_a, mode_pin_b, sw_i, sw_x_clr, step;
  logic        clock_fail_event, watchdog_timeout_event, nonmaskable_pin_request;
  logic        illegal_opcode_req, software_trap_req, cpu_i_mask, cpu_x_mask, instr_boundary;
  logic        vector_fetch, vector_valid, core_run, flags_mask_set, periph_init, expansion_bus;
  logic        watchdog_enable, osc_start_delay, clock_fail_detect_enable, irq_edge_select;
  logic        boot_rom_read, special_mode_flag, mode_a_latched, internal_read_visibility, onchip_rom_enable;
  logic [1:0]  reset_cause, watchdog_rate_select;
  logic [4:0]  modes;
  logic [5:0]  opts;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
  logic [14:0] maskable_req;
  logic [15:0] vector_addr, last_vec, boot_vec;
  int          errors, n_tests, n_vec, fetch_len, cyc;
  int          pidx [16] = '{10, 11, 12, 13, 14, 0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9};

  assign modes = {special_mode_flag, mode_a_latched, expansion_bus, boot_rom_read, internal_read_visibility};
  assign opts  = {osc_start_delay, clock_fail_detect_enable, watchdog_rate_select, irq_edge_select, watchdog_enable};

  rvip_top DUT (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_pin_a,
    .mode_pin_b, .clock_fail_event, .watchdog_timeout_event, .nonmaskable_pin_request, .illegal_opcode_req,
    .software_trap_req, .maskable_req, .cpu_i_mask, .cpu_x_mask, .instr_boundary, .vector_addr,
    .vector_fetch, .vector_valid, .core_run, .flags_mask_set, .reset_cause, .periph_init, .expansion_bus,
    .watchdog_enable, .watchdog_rate_select, .osc_start_delay, .clock_fail_detect_enable, .irq_edge_select,
    .boot_rom_read, .special_mode_flag, .mode_a_latched, .internal_read_visibility, .onchip_rom_enable);
  rvip_core_model core (.ref_clk, .rstn, .vector_addr, .vector_fetch, .vector_valid, .core_run,
    .flags_mask_set, .cpu_i_mask, .cpu_x_mask, .instr_boundary, .sw_i, .sw_x_clr, .step, .last_vec,
    .boot_vec, .n_vec, .fetch_len);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("BAD t=%0t timeout", $time);
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic note(input string what);
    $display("test %s done", what);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd = reg_rdata;
  endtask
  task automatic pwr(input logic a, b);
    @(posedge ref_clk);
    rstn       <= 1'b0;
    mode_pin_a <= a;
    mode_pin_b <= b;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  task automatic pulse_ev(input logic wd);
    @(posedge ref_clk);
    {watchdog_timeout_event, clock_fail_event} <= {wd, ~wd};
    @(posedge ref_clk);
    {watchdog_timeout_event, clock_fail_event} <= 2'b00;
  endtask
  task automatic mask(input logic i, xc);
    @(posedge ref_clk);
    sw_i     <= i;
    sw_x_clr <= xc;
    repeat (2) @(posedge ref_clk);
  endtask
  // waits out one restart and checks vector, fetch span and cause
  task automatic restart(input logic [15:0] v, input logic [1:0] c);
    int k;
    k = 0;
    while (vector_fetch !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    chk(16'({flags_mask_set, periph_init, core_run}), 16'h0006, "fetch state");
    while (core_run !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    chk(boot_vec, v, "restart vector");
    chk(16'(fetch_len), 16'h0003, "fetch cycles");
    chk(16'({reset_cause, flags_mask_set, periph_init}), 16'({c, 2'b00}), "run state");
  endtask
  // one boundary with the given requests; zero means no vector expected
  task automatic irq(input logic [14:0] m, input logic [2:0] n, input logic [15:0] exp);
    int n0;
    n0 = n_vec;
    @(posedge ref_clk);
    maskable_req <= m;
    {nonmaskable_pin_request, illegal_opcode_req, software_trap_req} <= n;
    step <= 1'b1;
    @(posedge ref_clk);
    step <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(16'(n_vec - n0), {15'h0, exp != 16'h0}, "vector count");
    if (exp != 16'h0)
      chk(last_vec, exp, "vector");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, mode_pin_a, mode_pin_b, step, sw_x_clr} = '0;
    {clock_fail_event, watchdog_timeout_event, nonmaskable_pin_request} = '0;
    {illegal_opcode_req, software_trap_req, maskable_req} = '0;
    sw_i = 1'b1;
    pwr(1'b0, 1'b1);
    restart(16'hFFFE, 2'h0);
    chk(16'(modes), 16'h0000, "normal modes");
    chk(16'(onchip_rom_enable), 16'h0001, "rom enable");
    chk(16'(opts), 16'h0021, "option outputs");
    rdr(RVIP_OFS_PRIO);
    chk(16'(rd), 16'h0005, "priority reset");
    rdr(RVIP_OFS_SETUP);
    chk(16'(rd), 16'h0002, "setup reset");
    rdr(RVIP_OFS_OPTION);
    chk(16'(rd), 16'h0010, "option reset");
    rdr(8'h00);
    chk(16'(rd), 16'h0000, "unmapped read");
    note("reset state");
    pulse_ev(1'b1);
    restart(16'hFFFA, 2'h2);
    wr(RVIP_OFS_OPTION, 8'h08);
    pulse_ev(1'b0);
    restart(16'hFFFC, 2'h1);
    chk(16'(opts), 16'h0021, "option after restart");
    note("internal restarts");
    mask(1'b0, 1'b0);
    irq(15'h7FFF, 3'b111, 16'hFFF8);
    mask(1'b0, 1'b1);
    irq(15'h7FFF, 3'b111, 16'hFFF4);
    irq(15'h7FFF, 3'b001, 16'hFFF6);
    irq(15'h7FFF, 3'b000, 16'hFFF2);
    irq(15'h6000, 3'b000, 16'hFFD8);
    mask(1'b1, 1'b1);
    irq(15'h7FFF, 3'b000, 16'h0000);
    note("fixed order");
    for (int p = 0; p < 16; p++) begin
      mask(1'b1, 1'b1);
      wr(RVIP_OFS_PRIO, 8'(p));
      rdr(RVIP_OFS_PRIO);
      chk(16'(rd), 16'(p), "priority select");
      mask(1'b0, 1'b1);
      irq(15'h7FFF, 3'b000, 16'hFFF2 - 16'(2 * pidx[p]));
      irq(15'h7FFF & ~(15'h1 << pidx[p]), 3'b000, pidx[p] == 0 ? 16'hFFF0 : 16'hFFF2);
    end
    wr(RVIP_OFS_PRIO, 8'h00);
    rdr(RVIP_OFS_PRIO);
    chk(16'(rd), 16'h000F, "priority unmasked write");
    mask(1'b1, 1'b1);
    wr(RVIP_OFS_PRIO, 8'h85);
    rdr(RVIP_OFS_PRIO);
    chk(16'(rd), 16'h0005, "priority guarded");
    note("promotion");
    wr(RVIP_OFS_SETUP, 8'h04);
    wr(RVIP_OFS_SETUP, 8'h00);
    rdr(RVIP_OFS_SETUP);
    chk(16'(rd), 16'h0006, "setup once");
    chk(16'(watchdog_enable), 16'h0000, "watchdog off");
    pulse_ev(1'b1);
    repeat (10) @(negedge ref_clk);
    chk(16'({core_run, vector_fetch}), 16'h0002, "no restart");
    note("watchdog disable");
    pwr(1'b1, 1'b0);
    restart(16'hBFFE, 2'h0);
    chk(16'(modes), 16'h001C, "special modes");
    chk(16'(watchdog_enable), 16'h0000, "watchdog off");
    rdr(RVIP_OFS_SETUP);
    chk(16'(rd), 16'h0006, "setup special");
    rdr(RVIP_OFS_PRIO);
    chk(16'(rd), 16'h0065, "priority special");
    wr(RVIP_OFS_SETUP, 8'h00);
    wr(RVIP_OFS_SETUP, 8'h04);
    wr(RVIP_OFS_SETUP, 8'h00);
    rdr(RVIP_OFS_SETUP);
    chk(16'(rd), 16'h0002, "setup rewrites");
    chk(16'(watchdog_enable), 16'h0001, "watchdog on");
    pulse_ev(1'b1);
    restart(16'hBFFA, 2'h2);
    wr(RVIP_OFS_OPTION, 8'h08);
    pulse_ev(1'b0);
    restart(16'hBFFC, 2'h1);
    mask(1'b1, 1'b1);
    wr(RVIP_OFS_PRIO, 8'hF5);
    rdr(RVIP_OFS_PRIO);
    chk(16'(rd), 16'h00F5, "boot read back");
    chk(16'({boot_rom_read, internal_read_visibility}), 16'h0003, "boot outputs");
    wr(RVIP_OFS_OPTION, 8'h23);
    rdr(RVIP_OFS_OPTION);
    chk(16'(rd), 16'h0023, "option special");
    chk(16'(opts), 16'h000E, "option outputs special");
    pwr(1'b0, 1'b0);
    restart(16'hBFFE, 2'h0);
    chk(16'(modes), 16'h0012, "bootstrap modes");
    rdr(RVIP_OFS_PRIO);
    chk(16'(rd), 16'h00C5, "priority bootstrap");
    note("special mode");
    print_verdict;
  end
endmodule
`default_nettype wire
